/* dv/dsl_led_observer.sv */
// operator model: measures whole on and off runs of one lamp
`timescale 1ns/1ps
`default_nettype none
module dsl_led_observer (
    input  wire logic        mclk,    // clock
    input  wire logic        clr,     // restart statistics
    input  wire logic        led,     // watched lamp
    output logic [15:0]      on_min,  // shortest on run
    output logic [15:0]      on_max,  // longest on run
    output logic [15:0]      off_min, // shortest off run
    output logic [15:0]      off_max  // longest off run
);
    logic [15:0] run;
    logic        last;
    logic        seen;
    // first run after clr is partial, so it is never recorded
    always_ff @(posedge mclk)
    begin
        if (clr)
        begin
            {run, seen, last} <= {16'h0001, 1'b0, led};
            {on_min, on_max, off_min, off_max} <= {16'hffff, 16'h0000, 16'hffff, 16'h0000};
        end
        else if (led == last)
            run <= run + 16'h0001;
        else
        begin
            {run, seen, last} <= {16'h0001, 1'b1, led};
            if (seen && last)
                {on_min, on_max} <= {(run < on_min) ? run : on_min, (run > on_max) ? run : on_max};
            if (seen && !last)
                {off_min, off_max} <= {(run < off_min) ? run : off_min,
                                       (run > off_max) ? run : off_max};
        end
    end
endmodule
`default_nettype wire

/* dv/dsl_top_assertions.sv */
// concurrent checks on the status led top ports
`timescale 1ns/1ps
`default_nettype none
module dsl_top_assertions #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic                  mclk,                   // clock
    input wire logic                  rstn,                   // reset
    input wire dsl_pkg::dsl_drive_t   drive,                  // drive
    input wire logic [1:0]            link_valid,             // link
    input wire logic [1:0]            link_activity,          // traffic
    input wire dsl_pkg::dsl_esm_t     esm_state,              // state
    input wire logic                  fw_download,            // download
    input wire logic [7:0]            al_change,              // flag
    input wire dsl_pkg::dsl_err_evt_t err_evt,                // events
    input wire logic                  alias_wr,               // strobe
    input wire logic [15:0]           alias_data,             // data
    input wire logic                  bridge_green_reg,       // green
    input wire logic                  bridge_red_reg,         // red
    input wire logic                  logic_supply_led,       // logic led
    input wire logic [1:0]            port_link_activity_led, // port leds
    input wire logic                  network_state_led,      // state led
    input wire logic                  network_error_led,      // error led
    input wire logic [15:0]           station_alias_reg,      // alias
    input wire logic [4:0]            err_pending_reg         // pending
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic green_cond;
    assign green_cond = !drive.fault && drive.dc_bus_ok && drive.enabled;
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_red; drive.fault |=> bridge_red_reg && !bridge_green_reg; endproperty
    property p_green; green_cond |=> bridge_green_reg && !bridge_red_reg; endproperty
    property p_logic; !drive.logic_ok ##1 drive.logic_ok |=> logic_supply_led; endproperty
    property p_link_off; !link_valid[0] |=> !port_link_activity_led[0]; endproperty
    property p_link_on; link_valid[1] && !link_activity[1] |=> port_link_activity_led[1];
    endproperty
    property p_op; esm_state == dsl_pkg::ESM_OP && !fw_download |=> network_state_led;
    endproperty
    property p_init; esm_state == dsl_pkg::ESM_INIT && !fw_download |=> !network_state_led;
    endproperty
    property p_pdi; err_evt.pdi_wdog |=> err_pending_reg[0] ##1 network_error_led; endproperty
    property p_dark; err_pending_reg == 5'h00 |=> !network_error_led; endproperty
    property p_refuse;
        err_evt.boot_fail && al_change != 8'h01 && !err_pending_reg[2] |=> !err_pending_reg[2];
    endproperty
    property p_alias; alias_wr |=> station_alias_reg == $past(alias_data); endproperty
    a_red: assert property (p_red) else $error("bridge red wrong");
    a_green: assert property (p_green) else $error("bridge green wrong");
    a_logic: assert property (p_logic) else $error("logic led wrong");
    a_link_off: assert property (p_link_off) else $error("port led not dark");
    a_link_on: assert property (p_link_on) else $error("port led not lit");
    a_op: assert property (p_op) else $error("state led not lit");
    a_init: assert property (p_init) else $error("state led not dark");
    a_pdi: assert property (p_pdi) else $error("watchdog not shown");
    a_dark: assert property (p_dark) else $error("error led lit idle");
    a_refuse: assert property (p_refuse) else $error("boot error taken");
    a_alias: assert property (p_alias) else $error("alias not stored");
    c_app: cover property (err_evt.app_wdog ##2 network_error_led);
    c_safeop: cover property (esm_state == dsl_pkg::ESM_SAFEOP ##1 network_state_led);
    c_alias: cover property (alias_wr);
endmodule
bind dsl_top dsl_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .mclk(mclk), .rstn(rstn), .drive(drive), .link_valid(link_valid),
    .link_activity(link_activity), .esm_state(esm_state), .fw_download(fw_download),
    .al_change(al_change), .err_evt(err_evt), .alias_wr(alias_wr), .alias_data(alias_data),
    .bridge_green_reg(bridge_green_reg), .bridge_red_reg(bridge_red_reg),
    .logic_supply_led(logic_supply_led), .port_link_activity_led(port_link_activity_led),
    .network_state_led(network_state_led), .network_error_led(network_error_led),
    .station_alias_reg(station_alias_reg), .err_pending_reg(err_pending_reg));
`default_nettype wire

/* dv/tb_drive_status_led_patterns.sv */
// self-checking bench for the status led top
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_drive_status_led_patterns;
    localparam int T = 4;
    logic mclk = 0, rstn = 0, fw_download = 0, alias_wr = 0, clr = 0;
    dsl_pkg::dsl_drive_t drive = '0;
    dsl_pkg::dsl_esm_t esm_state = dsl_pkg::ESM_INIT;
    dsl_pkg::dsl_err_evt_t err_evt = '0;
    logic [1:0] link_valid = 0, link_activity = 0, port_led, sel = 0;
    logic [7:0] al_change = 0;
    logic [4:0] err_clear = 0, pend;
    logic [15:0] alias_data = 0, alias_q, on_min, on_max, off_min, off_max;
    logic green, red, logic_led, st_led, er_led, obs_led;
    int fails = 0, samples_checked = 0, cyc = 0;
    always #50 mclk = ~mclk;
    assign obs_led = (sel == 0) ? st_led : (sel == 1) ? er_led : port_led[sel - 2];
    dsl_top #(.TICK_CYCLES(T)) dut (.mclk(mclk), .rstn(rstn), .drive(drive),
        .link_valid(link_valid), .link_activity(link_activity), .esm_state(esm_state),
        .fw_download(fw_download), .al_change(al_change), .err_evt(err_evt),
        .err_clear(err_clear), .alias_wr(alias_wr), .alias_data(alias_data),
        .bridge_green_reg(green), .bridge_red_reg(red), .logic_supply_led(logic_led),
        .port_link_activity_led(port_led), .network_state_led(st_led),
        .network_error_led(er_led), .station_alias_reg(alias_q), .err_pending_reg(pend));
    dsl_led_observer u_obs (.mclk(mclk), .clr(clr), .led(obs_led), .on_min(on_min),
        .on_max(on_max), .off_min(off_min), .off_max(off_max));
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, about 3.7 times the expected run
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            end_of_test();
        end
    end
    // on = 0 means steady at lvl; otherwise run lengths in slots
    task automatic obs(input logic [1:0] s, input int on, lo, hi, input logic lvl);
        logic [63:0] e;
        e = {16'hffff, 16'h0000, 16'hffff, 16'h0000};
        if (on != 0)
            e = {16'(on * T), 16'(on * T), 16'(lo * T), 16'(hi * T)};
        @(negedge mclk) sel = s;
        repeat (3) @(negedge mclk);
        clr = 1;
        @(negedge mclk) clr = 0;
        repeat (400) @(negedge mclk);
        `CHK("runs", e, {on_min, on_max, off_min, off_max})
        if (on == 0)
            `CHK("level", lvl, obs_led)
    endtask
    task automatic simple_leds;
        for (int i = 0; i < 16; i++)
        begin
            @(negedge mclk) drive = 4'(i);
            repeat (2) @(negedge mclk);
            `CHK("green", !drive.fault && drive.dc_bus_ok && drive.enabled, green)
            `CHK("red", drive.fault, red)
            `CHK("logic", drive.logic_ok, logic_led)
        end
    endtask
    task automatic port_leds;
        for (int i = 0; i < 3; i++)
        begin
            link_valid = {i != 0, i != 2};
            link_activity = {i == 2, i == 1};
            obs(2, (i == 1) ? 1 : 0, 1, 1, i == 0);
            obs(3, (i == 2) ? 1 : 0, 1, 1, i == 1);
        end
    endtask
    task automatic st(input dsl_pkg::dsl_esm_t e, input logic fw, input int on, lo, hi,
                      input logic lvl);
        esm_state = e;
        fw_download = fw;
        obs(0, on, lo, hi, lvl);
    endtask
    task automatic state_led;
        st(dsl_pkg::ESM_OP, 0, 0, 0, 0, 1);
        st(dsl_pkg::ESM_PREOP, 0, 4, 4, 4, 0);
        st(dsl_pkg::ESM_SAFEOP, 0, 4, 20, 20, 0);
        st(dsl_pkg::ESM_BOOT, 0, 1, 1, 1, 0);
        st(dsl_pkg::ESM_BOOTSTR, 0, 1, 1, 1, 0);
        st(dsl_pkg::ESM_OP, 1, 1, 1, 1, 0);
        st(dsl_pkg::ESM_INIT, 0, 0, 0, 0, 0);
    endtask
    task automatic raise(input logic [4:0] ev, input logic [4:0] cl);
        @(negedge mclk) {err_evt, err_clear} = {ev, cl};
        @(negedge mclk) {err_evt, err_clear} = 10'h000;
        @(negedge mclk);
    endtask
    task automatic errors;
        raise(5'h10, 0);
        `CHK("pending", 5'h01, pend)
        obs(1, 0, 0, 0, 1);
        raise(5'h04, 5'h01);
        obs(1, 4, 4, 4, 0);
        raise(5'h02, 5'h02);
        `CHK("refused", 5'h00, pend)
        obs(1, 0, 0, 0, 0);
        al_change = 8'h01;
        raise(5'h02, 0);
        obs(1, 1, 1, 1, 0);
        raise(5'h01, 5'h04);
        obs(1, 4, 20, 20, 0);
        raise(5'h08, 5'h08);
        obs(1, 4, 4, 20, 0);
        raise(5'h10, 0);
        obs(1, 0, 0, 0, 1);
        raise(0, 5'h11);
        `CHK("cleared", 5'h00, pend)
    endtask
    task automatic alias_write;
        @(negedge mclk) {alias_wr, alias_data} = {1'b1, 16'ha5c3};
        @(negedge mclk) alias_wr = 0;
        `CHK("alias", 16'ha5c3, alias_q)
    endtask
    initial
    begin
        repeat (2) @(negedge mclk);
        rstn = 1;
        `CHK("alias rst", dsl_pkg::ALIAS_RESET, alias_q)
        simple_leds();
        port_leds();
        state_led();
        errors();
        alias_write();
        end_of_test();
    end
endmodule
`default_nettype wire

/* src/dsl_pattern_gen.sv */
// timed led pattern generator: steady, blink, flashes, flicker
`timescale 1ns/1ps
`default_nettype none
module dsl_pattern_gen #(
    parameter int unsigned TICK_CYCLES = dsl_pkg::TICK_CYCLES
) (
    input  wire logic          mclk,    // system clock
    input  wire logic          rstn,    // async reset, low
    input  wire dsl_pkg::dsl_pattern_t mode, // selected pattern
    output logic               led_reg  // lamp drive, registered
);

    // ------------------------------------------------------------------
    // slot timebase
    // ------------------------------------------------------------------
    dsl_pkg::dsl_pattern_t mode_reg;
    logic [31:0]           tick_reg;
    logic [4:0]            slot_reg;
    logic [4:0]            period;
    logic                  restart;
    logic                  tick_end;

    assign restart  = (mode != mode_reg);
    assign tick_end = (tick_reg == TICK_CYCLES - 32'd1);

    always_comb
    begin
        unique case (mode)
            dsl_pkg::PAT_FLICKER: period = dsl_pkg::PERIOD_FLICKER;
            dsl_pkg::PAT_BLINK:   period = dsl_pkg::PERIOD_BLINK;
            dsl_pkg::PAT_SINGLE:  period = dsl_pkg::PERIOD_SINGLE;
            dsl_pkg::PAT_DOUBLE:  period = dsl_pkg::PERIOD_DOUBLE;
            default:              period = dsl_pkg::PERIOD_FLICKER;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            mode_reg <= dsl_pkg::PAT_OFF;
        else
            mode_reg <= mode;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tick_reg <= 32'h0000_0000;
            slot_reg <= 5'h00;
        end
        else if (restart)
        begin
            tick_reg <= 32'h0000_0000;
            slot_reg <= 5'h00;
        end
        else if (tick_end)
        begin
            tick_reg <= 32'h0000_0000;
            slot_reg <= (slot_reg == period - 5'h01) ? 5'h00 : slot_reg + 5'h01;
        end
        else
            tick_reg <= tick_reg + 32'h0000_0001;
    end

    // ------------------------------------------------------------------
    // lamp shape
    // ------------------------------------------------------------------
    // a new pattern shows its first slot from the cycle after the change
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            led_reg <= 1'b0;
        else if (restart)
            led_reg <= (mode != dsl_pkg::PAT_OFF);
        else
        begin
            unique case (mode)
                dsl_pkg::PAT_OFF:     led_reg <= 1'b0;
                dsl_pkg::PAT_ON:      led_reg <= 1'b1;
                dsl_pkg::PAT_FLICKER: led_reg <= ~slot_reg[0];
                dsl_pkg::PAT_BLINK,
                dsl_pkg::PAT_SINGLE:  led_reg <= (slot_reg < dsl_pkg::SLOT_FLASH);
                dsl_pkg::PAT_DOUBLE:  led_reg <= (slot_reg < dsl_pkg::SLOT_FLASH)
                    || (slot_reg >= 2 * dsl_pkg::SLOT_FLASH
                        && slot_reg < 3 * dsl_pkg::SLOT_FLASH);
                default:              led_reg <= 1'b0;
            endcase
        end
    end

endmodule
`default_nettype wire

/* src/dsl_pkg.sv */
// shared constants and types for the drive status led block
package dsl_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned TICK_MS     = 50;
    // one pattern slot is 50 ms; every pattern is built from whole slots
    localparam int unsigned TICK_CYCLES = (TICK_MS * CLK_HZ) / 1000;

    localparam logic [4:0] SLOT_FLASH     = 5'h04;  // 200 ms on or gap
    localparam logic [4:0] PERIOD_FLICKER = 5'h02;  // 50 on, 50 off
    localparam logic [4:0] PERIOD_BLINK   = 5'h08;  // 200 on, 200 off
    localparam logic [4:0] PERIOD_SINGLE  = 5'h18;  // 200 on, 1000 off
    localparam logic [4:0] PERIOD_DOUBLE  = 5'h20;  // 200,200,200 then 1000 off
    localparam logic [7:0] AL_CHANGE_SET  = 8'h01;
    localparam logic [15:0] ALIAS_RESET   = 16'h0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        PAT_OFF     = 6'b00_0001,
        PAT_ON      = 6'b00_0010,
        PAT_BLINK   = 6'b00_0100,
        PAT_SINGLE  = 6'b00_1000,
        PAT_DOUBLE  = 6'b01_0000,
        PAT_FLICKER = 6'b10_0000
    } dsl_pattern_t;

    typedef enum logic [5:0] {
        ESM_BOOT    = 6'b00_0001,
        ESM_INIT    = 6'b00_0010,
        ESM_PREOP   = 6'b00_0100,
        ESM_SAFEOP  = 6'b00_1000,
        ESM_OP      = 6'b01_0000,
        ESM_BOOTSTR = 6'b10_0000
    } dsl_esm_t;

    typedef struct packed {
        logic dc_bus_ok;
        logic enabled;
        logic fault;
        logic logic_ok;
    } dsl_drive_t;

    // one bit per error source, index order fixed
    localparam int ERR_PDI_WDOG = 0;
    localparam int ERR_CONFIG   = 1;
    localparam int ERR_BOOT     = 2;
    localparam int ERR_AUTO     = 3;
    localparam int ERR_APP_WDOG = 4;
    localparam int ERR_N        = 5;

    typedef struct packed {
        logic pdi_wdog;
        logic app_wdog;
        logic config_err;
        logic boot_fail;
        logic auto_change;
    } dsl_err_evt_t;

endpackage

/* src/dsl_top.sv */
// drive and network status indicator logic
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - bridge led green with bus power and enable, red on any fault.
// - logic supply led green while logic power is present.
// - link led on for idle link, flicker with traffic, off without link.
// - network state led steady green in operational.
// - network state led blinks 200 ms on, 200 ms off in pre-operational.
// - safe-operational gives 200 ms flash then 1000 ms dark, repeating.
// - flicker 50/50 ms while booting, in bootstrap or downloading firmware.
// - network state led dark in init.
// - error led steady red after interface watchdog timeout.
// - error led blinks 200/200 ms on configuration error.
// - error led flickers on boot error: init reached, change flag 01.
// - error led single flash on autonomous state change with change flag 01.
// - error led double flash on application watchdog timeout.
// - station alias writable by network or setup.
module dsl_top #(
    parameter int unsigned TICK_CYCLES = dsl_pkg::TICK_CYCLES
) (
    input  wire logic                mclk,              // system clock
    input  wire logic                rstn,              // async reset, low
    input  wire dsl_pkg::dsl_drive_t drive,             // drive core status
    input  wire logic [1:0]          link_valid,        // per port link up
    input  wire logic [1:0]          link_activity,     // per port traffic
    input  wire dsl_pkg::dsl_esm_t   esm_state,         // slave state machine
    input  wire logic                fw_download,       // firmware download busy
    input  wire logic [7:0]          al_change,         // status change flag
    input  wire dsl_pkg::dsl_err_evt_t err_evt,         // error event pulses
    input  wire logic [4:0]          err_clear,         // per error clear pulses
    input  wire logic                alias_wr,          // alias write strobe
    input  wire logic [15:0]         alias_data,        // alias write data
    output logic                     bridge_green_reg,  // bridge led green
    output logic                     bridge_red_reg,    // bridge led red
    output logic                     logic_supply_led,  // logic power led
    output logic [1:0]               port_link_activity_led, // per port led
    output logic                     network_state_led, // green state led
    output logic                     network_error_led, // red error led
    output logic [15:0]              station_alias_reg, // stored alias
    output logic [4:0]               err_pending_reg    // pending errors
);

    // ------------------------------------------------------------------
    // drive power leds
    // ------------------------------------------------------------------
    // fault beats green
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bridge_green_reg <= 1'b0;
            bridge_red_reg   <= 1'b0;
        end
        else
        begin
            bridge_red_reg   <= drive.fault;
            bridge_green_reg <= ~drive.fault & drive.dc_bus_ok & drive.enabled;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            logic_supply_led <= 1'b0;
        else
            logic_supply_led <= drive.logic_ok;
    end

    // ------------------------------------------------------------------
    // port link leds
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            dsl_pkg::dsl_pattern_t port_mode;
            assign port_mode = !link_valid[p] ? dsl_pkg::PAT_OFF :
                               link_activity[p] ? dsl_pkg::PAT_FLICKER :
                               dsl_pkg::PAT_ON;
            dsl_pattern_gen #(
                .TICK_CYCLES (TICK_CYCLES)
            ) u_port (
                .mclk    (mclk),
                .rstn    (rstn),
                .mode    (port_mode),
                .led_reg (port_link_activity_led[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // network state led
    // ------------------------------------------------------------------
    dsl_pkg::dsl_pattern_t state_mode;

    always_comb
    begin
        if (fw_download)
            state_mode = dsl_pkg::PAT_FLICKER;
        else
        begin
            unique case (esm_state)
                dsl_pkg::ESM_OP:      state_mode = dsl_pkg::PAT_ON;
                dsl_pkg::ESM_PREOP:   state_mode = dsl_pkg::PAT_BLINK;
                dsl_pkg::ESM_SAFEOP:  state_mode = dsl_pkg::PAT_SINGLE;
                dsl_pkg::ESM_BOOT,
                dsl_pkg::ESM_BOOTSTR: state_mode = dsl_pkg::PAT_FLICKER;
                dsl_pkg::ESM_INIT:    state_mode = dsl_pkg::PAT_OFF;
                // an illegal state code is shown dark
                default:              state_mode = dsl_pkg::PAT_OFF;
            endcase
        end
    end

    dsl_pattern_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_state (
        .mclk    (mclk),
        .rstn    (rstn),
        .mode    (state_mode),
        .led_reg (network_state_led)
    );

    // ------------------------------------------------------------------
    // error capture
    // ------------------------------------------------------------------
    logic [4:0] err_set;
    logic       change_flag;

    assign change_flag = (al_change == dsl_pkg::AL_CHANGE_SET);

    always_comb
    begin
        err_set = 5'h00;
        err_set[dsl_pkg::ERR_PDI_WDOG] = err_evt.pdi_wdog;
        err_set[dsl_pkg::ERR_CONFIG]   = err_evt.config_err;
        err_set[dsl_pkg::ERR_BOOT]     = err_evt.boot_fail & change_flag
                                         & (esm_state == dsl_pkg::ESM_INIT);
        err_set[dsl_pkg::ERR_AUTO]     = err_evt.auto_change & change_flag;
        err_set[dsl_pkg::ERR_APP_WDOG] = err_evt.app_wdog;
    end

    // set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            err_pending_reg <= 5'h00;
        else
            err_pending_reg <= (err_pending_reg & ~err_clear) | err_set;
    end

    // ------------------------------------------------------------------
    // newest error selection
    // ------------------------------------------------------------------
    logic [2:0] last_reg;
    logic [2:0] last_next;
    logic [4:0] pend_next;

    assign pend_next = (err_pending_reg & ~err_clear) | err_set;

    always_comb
    begin
        last_next = last_reg;
        if (err_set != 5'h00)
        begin
            // simultaneous raises: highest index taken as newest
            for (int i = 0; i < dsl_pkg::ERR_N; i++)
                if (err_set[i])
                    last_next = 3'(i);
        end
        else if (!pend_next[last_reg])
        begin
            // newest one cleared: history is not kept, fall back by index
            for (int i = dsl_pkg::ERR_N - 1; i >= 0; i--)
                if (pend_next[i])
                    last_next = 3'(i);
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            last_reg <= 3'h0;
        else
            last_reg <= last_next;
    end

    dsl_pkg::dsl_pattern_t err_mode;

    always_comb
    begin
        if (err_pending_reg == 5'h00)
            err_mode = dsl_pkg::PAT_OFF;
        else
        begin
            unique case (last_reg)
                3'h0:    err_mode = dsl_pkg::PAT_ON;
                3'h1:    err_mode = dsl_pkg::PAT_BLINK;
                3'h2:    err_mode = dsl_pkg::PAT_FLICKER;
                3'h3:    err_mode = dsl_pkg::PAT_SINGLE;
                3'h4:    err_mode = dsl_pkg::PAT_DOUBLE;
                default: err_mode = dsl_pkg::PAT_OFF;
            endcase
        end
    end

    dsl_pattern_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_error (
        .mclk    (mclk),
        .rstn    (rstn),
        .mode    (err_mode),
        .led_reg (network_error_led)
    );

    // ------------------------------------------------------------------
    // station alias
    // ------------------------------------------------------------------
    // alias write port
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            station_alias_reg <= dsl_pkg::ALIAS_RESET;
        else if (alias_wr)
            station_alias_reg <= alias_data;
    end

endmodule
`default_nettype wire
